// ===== rtl/ica_defs.svh
// constants for the interrupt acceptance block: offsets, fields, resets
`ifndef ICA_DEFS_SVH
`define ICA_DEFS_SVH

// ---------------------------------------------------------------
// source table
// ---------------------------------------------------------------
`define ICA_NUM_SRC 28
// control register offsets, index 0 in the low byte
`define ICA_SRC_OFFS {8'h73, 8'h72, 8'h6B, 8'h5E, 8'h5D, 8'h5A, 8'h59, \
    8'h58, 8'h56, 8'h55, 8'h54, 8'h53, 8'h52, 8'h51, 8'h4F, 8'h4E, \
    8'h4D, 8'h4C, 8'h4B, 8'h4A, 8'h49, 8'h48, 8'h47, 8'h46, 8'h45, \
    8'h44, 8'h43, 8'h41}
// external pin number per source, 4'hF where the source is no pin
`define ICA_SRC_PIN 112'hFFFF031FF2FFFFFFFFFFFFF4567F
`define ICA_PIN_NONE 4'hF
// index of the source shared by sync serial and two-wire units
`define ICA_SHARED_SRC 13

// ---------------------------------------------------------------
// own register offsets
// ---------------------------------------------------------------
`define ICA_ADDR_FLAG 8'h30
`define ICA_ADDR_STAT 8'h31
`define ICA_ADDR_MASK 8'h32
`define ICA_ADDR_SSMODE 8'h33

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define ICA_IC_LVL_LSB 0
`define ICA_IC_REQ_BIT 3
`define ICA_IC_POL_BIT 4
`define ICA_IC_BOTH_BIT 5
`define ICA_FLAG_I_BIT 0
`define ICA_FLAG_U_BIT 1
`define ICA_FLAG_IPL_LSB 4
`define ICA_STAT_ACC_BIT 0
`define ICA_STAT_SWI_BIT 1
`define ICA_STAT_HELD_BIT 2
`define ICA_SS_SEL_BIT 0

// ---------------------------------------------------------------
// reset values and limits
// ---------------------------------------------------------------
`define ICA_IC_RST 8'h00
`define ICA_FLAG_RST 8'h00
`define ICA_STAT_RST 3'h0
`define ICA_PIN_RST 8'hFF
`define ICA_SWI_U_MAX 6'h1F

`endif

// ===== rtl/ica_pkg.sv
// types shared by the interrupt acceptance block
package ica_pkg;
    typedef logic [2:0] ica_lvl_t;
    typedef logic [7:0] ica_byte_t;
    typedef logic [4:0] ica_idx_t;
    typedef enum logic [0:0] {ICA_ST_IDLE, ICA_ST_OFFER} ica_state_e;
endpackage

// ===== rtl/ica_top.sv
// processor-side interrupt acceptance with per-source control registers
//
// How it works
// (RQ1) No maskable request is offered while the enable flag is 0; at 1 they are considered.
// (RQ2) Accepting a request clears the enable flag so no nested request is taken.
// (RQ3) The stack pointer output follows the interrupt pointer at U=0 and the user one at U=1.
// (RQ4) U is cleared on accepting a hardware request and on software interrupts 0 to 31.
// (RQ5) The processor priority level is a three-bit field holding 0 to 7.
// (RQ6) A request is offered only when its level is strictly above the processor level.
// (RQ7) The reserved flag bit is written as 0 by software and reads back with no meaning.
// (RQ8) Reset clears the low three bits of every control register and bits 4 and 5 of pin ones.
// (RQ9) Software must not touch unassigned offsets; writes there are dropped, reads give 0.
// (RQ10) The shared register takes the sync serial or two-wire event as the select bit says.
// (RQ11) Each control register holds a three-bit source level; level 0 is never accepted.
//
// Design decision made here: the strobed register port.
`include "ica_defs.svh"

module ica_top
    import ica_pkg::*;
#(
    parameter int NUM_SRC = `ICA_NUM_SRC
) (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clk_en,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // peripheral events and pins
    input wire logic [NUM_SRC-1:0] src_evt,
    input wire logic twowire_evt,
    input wire logic [7:0] ext_pin,
    // cpu sequencer side
    output logic cpu_req,
    output logic [4:0] cpu_vec,
    output logic [2:0] cpu_lvl,
    input wire logic cpu_ack,
    input wire logic sw_int,
    input wire logic [5:0] sw_int_num,
    // stack pointers
    input wire logic [15:0] isp_in,
    input wire logic [15:0] usp_in,
    output logic [15:0] active_sp,
    output logic use_user_sp,
    // interrupt line
    output logic irq
);

    // ---------------------------------------------------------------
    // tables and checks
    // ---------------------------------------------------------------
    localparam logic [8*`ICA_NUM_SRC-1:0] SRC_OFFS = `ICA_SRC_OFFS;
    localparam logic [4*`ICA_NUM_SRC-1:0] SRC_PIN = `ICA_SRC_PIN;
    localparam int SHARED = `ICA_SHARED_SRC;

    if (NUM_SRC != `ICA_NUM_SRC) begin : g_chk
        $error("NUM_SRC must match the fixed source table");
    end

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    ica_byte_t ic_r [NUM_SRC];
    logic flag_i_r;
    logic flag_u_r;
    ica_lvl_t flag_ipl_r;
    logic [2:0] stat_r;
    logic [2:0] mask_r;
    logic ss_sel_r;
    ica_state_e state_r;
    ica_idx_t vec_r;
    ica_lvl_t lvl_r;
    logic [7:0] pin_s1_r;
    logic [7:0] pin_s2_r;
    logic [7:0] pin_prev_r;
    logic [7:0] rdata_r;
    logic [15:0] sp_r;

    logic [NUM_SRC-1:0] evt;
    logic [NUM_SRC-1:0] wr_hit;
    logic [NUM_SRC-1:0] ack_hit;
    logic win_valid;
    ica_idx_t win_idx;
    ica_lvl_t win_lvl;
    logic still_ok;
    logic accept;
    logic swi_clr_u;
    logic flag_wr;
    logic [7:0] rd_val;

    // ---------------------------------------------------------------
    // pin synchronisers and edge detect
    // ---------------------------------------------------------------
    // two synchroniser flops and one edge flop per pin, reset to the idle-high level so no false edge
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pin_s1_r <= `ICA_PIN_RST;
            pin_s2_r <= `ICA_PIN_RST;
            pin_prev_r <= `ICA_PIN_RST;
        end else if (clk_en) begin
            pin_s1_r <= ext_pin;
            pin_s2_r <= pin_s1_r;
            pin_prev_r <= pin_s2_r;
        end
    end

    // ---------------------------------------------------------------
    // per-source control registers
    // ---------------------------------------------------------------
    for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
        localparam logic [7:0] OFF = SRC_OFFS[8*g +: 8];
        localparam logic [3:0] PIN = SRC_PIN[4*g +: 4];
        logic rise;
        logic fall;

        if (PIN != `ICA_PIN_NONE) begin : g_pin
            assign rise = pin_s2_r[PIN[2:0]] && !pin_prev_r[PIN[2:0]];
            assign fall = !pin_s2_r[PIN[2:0]] && pin_prev_r[PIN[2:0]];
            // bit 5 takes both edges, else bit 4 picks rising
            assign evt[g] = ic_r[g][`ICA_IC_BOTH_BIT] ? (rise || fall) :
                ic_r[g][`ICA_IC_POL_BIT] ? rise : fall;
        end else if (g == SHARED) begin : g_shr
            assign rise = 1'b0;
            assign fall = 1'b0;
            // one register, two possible owners
            assign evt[g] = ss_sel_r ? twowire_evt : src_evt[g]; // see (RQ10)
        end else begin : g_int
            assign rise = 1'b0;
            assign fall = 1'b0;
            assign evt[g] = src_evt[g];
        end

        assign wr_hit[g] = reg_wr && (reg_addr == OFF);
        assign ack_hit[g] = accept && (vec_r == ica_idx_t'(g));

        // request flag: event wins over a clear by write or by acceptance
        always_ff @(posedge ref_clk) begin
            if (reset) begin
                ic_r[g] <= `ICA_IC_RST; // see (RQ8)
            end else if (clk_en) begin
                if (wr_hit[g]) begin
                    ic_r[g][2:0] <= reg_wdata[2:0]; // see (RQ11)
                    ic_r[g][7:4] <= reg_wdata[7:4];
                end
                if (evt[g]) begin
                    ic_r[g][`ICA_IC_REQ_BIT] <= 1'b1;
                end else if (ack_hit[g]) begin
                    ic_r[g][`ICA_IC_REQ_BIT] <= 1'b0;
                end else if (wr_hit[g] && !reg_wdata[`ICA_IC_REQ_BIT]) begin
                    ic_r[g][`ICA_IC_REQ_BIT] <= 1'b0;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // arbitration
    // ---------------------------------------------------------------
    // highest level wins, lowest index on a tie
    always_comb begin
        win_valid = 1'b0;
        win_idx = '0;
        win_lvl = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (ic_r[i][`ICA_IC_REQ_BIT] && (ic_r[i][2:0] > flag_ipl_r) &&
                (!win_valid || (ic_r[i][2:0] > win_lvl))) begin // see (RQ6)
                win_valid = 1'b1;
                win_idx = ica_idx_t'(i);
                win_lvl = ic_r[i][2:0];
            end
        end
    end

    // an offered request is withdrawn as soon as I clears, its request flag clears or its latched level is no longer above the processor level
    assign still_ok = flag_i_r && ic_r[vec_r][`ICA_IC_REQ_BIT] &&
        (lvl_r > flag_ipl_r); // see (RQ1)
    assign cpu_req = (state_r == ICA_ST_OFFER) && still_ok;
    assign accept = cpu_req && cpu_ack && clk_en;
    assign cpu_vec = vec_r;
    assign cpu_lvl = lvl_r;

    // ---------------------------------------------------------------
    // offer state machine
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_r <= ICA_ST_IDLE;
            vec_r <= '0;
            lvl_r <= '0;
        end else if (clk_en) begin
            case (state_r)
                ICA_ST_IDLE: begin
                    if (win_valid && flag_i_r) begin // see (RQ1)
                        state_r <= ICA_ST_OFFER;
                        vec_r <= win_idx;
                        lvl_r <= win_lvl;
                    end
                end
                ICA_ST_OFFER: begin
                    if (accept || !still_ok) begin
                        state_r <= ICA_ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ICA_ST_IDLE;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // flag register: I, U, processor level
    // ---------------------------------------------------------------
    assign flag_wr = reg_wr && (reg_addr == `ICA_ADDR_FLAG);
    assign swi_clr_u = sw_int && (sw_int_num <= `ICA_SWI_U_MAX);

    // hardware clears win over a software write in the same cycle
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            flag_i_r <= 1'(`ICA_FLAG_RST >> `ICA_FLAG_I_BIT);
            flag_u_r <= 1'b0;
            flag_ipl_r <= '0;
        end else if (clk_en) begin
            if (accept) begin
                flag_i_r <= 1'b0; // see (RQ2)
                flag_ipl_r <= lvl_r; // see (RQ5)
            end else if (flag_wr) begin
                flag_i_r <= reg_wdata[`ICA_FLAG_I_BIT];
                flag_ipl_r <= reg_wdata[`ICA_FLAG_IPL_LSB +: 3]; // see (RQ5)
            end
            if (accept || swi_clr_u) begin
                flag_u_r <= 1'b0; // see (RQ4)
            end else if (flag_wr) begin
                flag_u_r <= reg_wdata[`ICA_FLAG_U_BIT];
            end
        end
    end

    // ---------------------------------------------------------------
    // stack pointer select
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sp_r <= 16'h0000;
        end else if (clk_en) begin
            sp_r <= flag_u_r ? usp_in : isp_in; // see (RQ3)
        end
    end
    assign active_sp = sp_r;
    assign use_user_sp = flag_u_r;

    // ---------------------------------------------------------------
    // event status, mask, mode select
    // ---------------------------------------------------------------
    // sticky events, write one to clear, a new event wins
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            stat_r <= `ICA_STAT_RST;
            mask_r <= 3'h0;
            ss_sel_r <= 1'b0;
        end else if (clk_en) begin
            for (int b = 0; b < 3; b++) begin
                if (reg_wr && reg_addr == `ICA_ADDR_STAT && reg_wdata[b]) begin
                    stat_r[b] <= 1'b0;
                end
            end
            if (accept) begin
                stat_r[`ICA_STAT_ACC_BIT] <= 1'b1;
            end
            if (sw_int) begin
                stat_r[`ICA_STAT_SWI_BIT] <= 1'b1;
            end
            if (win_valid && !flag_i_r) begin
                stat_r[`ICA_STAT_HELD_BIT] <= 1'b1;
            end
            if (reg_wr && reg_addr == `ICA_ADDR_MASK) begin
                mask_r <= reg_wdata[2:0];
            end
            if (reg_wr && reg_addr == `ICA_ADDR_SSMODE) begin
                ss_sel_r <= reg_wdata[`ICA_SS_SEL_BIT]; // see (RQ10)
            end
        end
    end
    assign irq = |(stat_r & mask_r);

    // ---------------------------------------------------------------
    // register read
    // ---------------------------------------------------------------
    // reserved flag bit and unassigned offsets read as zero
    always_comb begin
        rd_val = 8'h00;
        if (reg_addr == `ICA_ADDR_FLAG) begin
            rd_val = {1'b0, flag_ipl_r, 2'b00, flag_u_r, flag_i_r}; // see (RQ7)
        end else if (reg_addr == `ICA_ADDR_STAT) begin
            rd_val = {5'h00, stat_r};
        end else if (reg_addr == `ICA_ADDR_MASK) begin
            rd_val = {5'h00, mask_r};
        end else if (reg_addr == `ICA_ADDR_SSMODE) begin
            rd_val = {7'h00, ss_sel_r};
        end else begin
            for (int i = 0; i < NUM_SRC; i++) begin
                if (reg_addr == SRC_OFFS[8*i +: 8]) begin
                    rd_val = ic_r[i]; // see (RQ9)
                end
            end
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rdata_r <= 8'h00;
        end else if (clk_en) begin
            rdata_r <= reg_rd ? rd_val : 8'h00;
        end
    end
    assign reg_rdata = rdata_r;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    sequence s_accept;
        cpu_req && cpu_ack && clk_en;
    endsequence

    sequence s_after_accept;
        !flag_i_r && !flag_u_r && (flag_ipl_r == $past(lvl_r));
    endsequence

    property p_offer_enabled;
        @(posedge ref_clk) disable iff (reset)
        cpu_req |-> flag_i_r;
    endproperty
    a_offer_enabled: assert property (p_offer_enabled) // see (RQ1)
        else $error("request offered with enable flag clear");

    property p_accept_flags;
        @(posedge ref_clk) disable iff (reset)
        s_accept |=> s_after_accept;
    endproperty
    a_accept_flags: assert property (p_accept_flags) // see (RQ2)
        else $error("flags wrong after acceptance");

    property p_sp_follow;
        @(posedge ref_clk) disable iff (reset)
        (!reset && clk_en) |=> active_sp == ($past(flag_u_r) ? $past(usp_in) :
            $past(isp_in));
    endproperty
    a_sp_follow: assert property (p_sp_follow) // see (RQ3)
        else $error("active stack pointer does not follow U");

    property p_swi_u;
        @(posedge ref_clk) disable iff (reset)
        (clk_en && sw_int && sw_int_num <= 6'h1F) |=> !flag_u_r;
    endproperty
    a_swi_u: assert property (p_swi_u) // see (RQ4)
        else $error("U not cleared by low software interrupt");

    property p_level_above;
        @(posedge ref_clk) disable iff (reset)
        cpu_req |-> (cpu_lvl > flag_ipl_r) && (cpu_lvl != 3'h0);
    endproperty
    a_level_above: assert property (p_level_above) // see (RQ6)
        else $error("offered level not above processor level");

    property p_no_renest;
        @(posedge ref_clk) disable iff (reset)
        s_accept ##1 (!flag_wr) [*2] |-> !cpu_req;
    endproperty
    a_no_renest: assert property (p_no_renest) // see (RQ2)
        else $error("request offered again without re-enable");

    property p_shared_sel;
        @(posedge ref_clk) disable iff (reset)
        (clk_en && ss_sel_r && twowire_evt) |=>
            ic_r[SHARED][`ICA_IC_REQ_BIT];
    endproperty
    a_shared_sel: assert property (p_shared_sel) // see (RQ10)
        else $error("two-wire event lost on shared register");

    property p_accept_status;
        @(posedge ref_clk) disable iff (reset)
        s_accept |=> stat_r[0] && (irq == mask_r[0] || irq);
    endproperty
    a_accept_status: assert property (p_accept_status)
        else $error("acceptance event not recorded");

    property p_read_slot;
        @(posedge ref_clk) disable iff (reset)
        (clk_en && !reg_rd) |=> reg_rdata == 8'h00;
    endproperty
    a_read_slot: assert property (p_read_slot) // see (RQ9)
        else $error("read data outside its slot");

endmodule

// ===== sim/ica_cpu_model.sv
// cpu sequencer model that takes offered requests after a chosen delay
module ica_cpu_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // request side
    input wire logic cpu_req,
    input wire logic [3:0] ack_dly,
    // accept side
    output logic cpu_ack,
    output logic [7:0] ack_cnt
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] wait_r;

    // count cycles of an offer, then pulse accept once; never accept
    // without an offer standing
    always @(posedge ref_clk) begin
        if (reset) begin
            wait_r <= 4'h0;
            cpu_ack <= 1'b0;
            ack_cnt <= 8'h00;
        end else begin
            wait_r <= cpu_req ? wait_r + 4'h1 : 4'h0;
            cpu_ack <= cpu_req && !cpu_ack && (wait_r >= ack_dly);
            if (cpu_ack && cpu_req) begin
                ack_cnt <= ack_cnt + 8'h01;
            end
        end
    end
endmodule

// ===== sim/testbench.sv
// self-checking bench for the interrupt acceptance block
`include "ica_defs.svh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
    $display("BAD %s exp %h got %h", n, e, g); mismatches++; end end

module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [8*28-1:0] OFFS = `ICA_SRC_OFFS;
    localparam logic [15:0] ISP_V = 16'h1111;
    localparam logic [15:0] USP_V = 16'h2222;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic clk_en = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [27:0] src_evt = 28'h0;
    logic twowire_evt = 1'b0;
    logic [7:0] ext_pin = 8'hFF;
    logic cpu_req;
    logic [4:0] cpu_vec;
    logic [2:0] cpu_lvl;
    logic cpu_ack;
    logic sw_int = 1'b0;
    logic [5:0] sw_int_num = 6'h00;
    logic [15:0] active_sp;
    logic use_user_sp;
    logic irq;
    logic [3:0] ack_dly = 4'h0;
    logic [7:0] ack_cnt;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;

    // 40 MHz clock
    always #12.5 ref_clk = ~ref_clk;

    ica_top i_dut (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_evt(src_evt),
        .twowire_evt(twowire_evt), .ext_pin(ext_pin), .cpu_req(cpu_req),
        .cpu_vec(cpu_vec), .cpu_lvl(cpu_lvl), .cpu_ack(cpu_ack),
        .sw_int(sw_int), .sw_int_num(sw_int_num), .isp_in(ISP_V),
        .usp_in(USP_V), .active_sp(active_sp), .use_user_sp(use_user_sp),
        .irq(irq));

    ica_cpu_model i_cpu (.ref_clk(ref_clk), .reset(reset),
        .cpu_req(cpu_req), .ack_dly(ack_dly), .cpu_ack(cpu_ack),
        .ack_cnt(ack_cnt));

    // verdict and end of run
    task automatic finish_test();
        if (mismatches == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    // one-cycle read strobe, data looked at in the following cycle
    task automatic rd(input logic [7:0] a, input logic [7:0] e,
        input string n);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(n, e, reg_rdata)
    endtask

    // one-cycle event pulses
    task automatic pulse(input logic [27:0] s, input logic t,
        input logic w, input logic [5:0] num);
        @(posedge ref_clk);
        src_evt <= s;
        twowire_evt <= t;
        sw_int <= w;
        sw_int_num <= num;
        @(posedge ref_clk);
        src_evt <= 28'h0;
        twowire_evt <= 1'b0;
        sw_int <= 1'b0;
        repeat (4) @(posedge ref_clk);
        #1;
    endtask

    // wait for an offer to appear (up) or go away (down)
    task automatic wait_req(input logic up);
        for (int i = 0; i < 20 && cpu_req !== up; i++) begin
            @(posedge ref_clk);
            #1;
        end
        `CHK("cpu_req", up, cpu_req)
    endtask

    // cut a hang short
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            finish_test();
        end
    end

    // main sequence
    initial begin
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        for (int i = 0; i < 28; i++) begin
            rd(OFFS[i*8 +: 8], 8'h00, "ctrl reset");
        end
        rd(`ICA_ADDR_FLAG, 8'h00, "flag reset");
        // unmapped places drop writes and read 0
        wr(8'h42, 8'hFF);
        wr(8'h50, 8'hFF);
        rd(8'h42, 8'h00, "unmapped");
        rd(8'h50, 8'h00, "unmapped");
        // request flag cannot be set by software
        wr(8'h47, 8'hFF);
        rd(8'h47, 8'hF7, "ctrl rw");
        wr(8'h47, 8'h03);
        // I=1, U=1, PROCESSOR_PRIORITY_LEVEL=3, reserved bit written 0
        wr(`ICA_ADDR_FLAG, 8'h33);
        rd(`ICA_ADDR_FLAG, 8'h33, "flag rw");
        repeat (3) @(posedge ref_clk);
        #1;
        `CHK("active_sp", USP_V, active_sp)
        // level equal to PROCESSOR_PRIORITY_LEVEL is not offered
        pulse(28'h20, 1'b0, 1'b0, 6'h00);
        `CHK("cpu_req", 1'b0, cpu_req)
        rd(8'h47, 8'h0B, "ctrl pending");
        // level above PROCESSOR_PRIORITY_LEVEL is offered, slow accept
        ack_dly <= 4'h4;
        wr(`ICA_ADDR_MASK, 8'h01);
        wr(8'h47, 8'h0C);
        wait_req(1'b1);
        `CHK("cpu_vec", 5'd5, cpu_vec)
        `CHK("cpu_lvl", 3'd4, cpu_lvl)
        wait_req(1'b0);
        `CHK("ack_cnt", 8'h01, ack_cnt)
        rd(`ICA_ADDR_FLAG, 8'h40, "flag acc");
        repeat (2) @(posedge ref_clk);
        #1;
        `CHK("active_sp", ISP_V, active_sp)
        `CHK("irq", 1'b1, irq)
        rd(`ICA_ADDR_STAT, 8'h01, "stat acc");
        wr(`ICA_ADDR_STAT, 8'h01);
        rd(`ICA_ADDR_STAT, 8'h00, "stat clr");
        `CHK("irq", 1'b0, irq)
        // enable flag low holds a qualifying request off
        ack_dly <= 4'h0;
        wr(`ICA_ADDR_FLAG, 8'h00);
        pulse(28'h20, 1'b0, 1'b0, 6'h00);
        `CHK("cpu_req", 1'b0, cpu_req)
        rd(`ICA_ADDR_STAT, 8'h04, "stat held");
        wr(`ICA_ADDR_MASK, 8'h04);
        #1;
        `CHK("irq", 1'b1, irq)
        wr(`ICA_ADDR_MASK, 8'h00);
        #1;
        `CHK("irq", 1'b0, irq)
        wr(`ICA_ADDR_FLAG, 8'h01);
        wait_req(1'b1);
        wait_req(1'b0);
        `CHK("ack_cnt", 8'h02, ack_cnt)
        wr(`ICA_ADDR_STAT, 8'h07);
        // software interrupts: 32 keeps U, 31 clears it
        wr(`ICA_ADDR_FLAG, 8'h02);
        pulse(28'h0, 1'b0, 1'b1, 6'd32);
        `CHK("use_user_sp", 1'b1, use_user_sp)
        pulse(28'h0, 1'b0, 1'b1, 6'd31);
        `CHK("use_user_sp", 1'b0, use_user_sp)
        // shared register follows the select bit
        pulse(28'h0, 1'b1, 1'b0, 6'h00);
        rd(8'h4F, 8'h00, "shared ss");
        pulse(28'h2000, 1'b0, 1'b0, 6'h00);
        rd(8'h4F, 8'h08, "shared ss");
        wr(8'h4F, 8'h00);
        wr(`ICA_ADDR_SSMODE, 8'h01);
        rd(`ICA_ADDR_SSMODE, 8'h01, "ss mode");
        pulse(28'h2000, 1'b0, 1'b0, 6'h00);
        rd(8'h4F, 8'h00, "shared tw");
        pulse(28'h0, 1'b1, 1'b0, 6'h00);
        rd(8'h4F, 8'h08, "shared tw");
        // falling edge on a pin sets its request flag
        @(posedge ref_clk);
        ext_pin <= 8'h7F;
        repeat (6) @(posedge ref_clk);
        rd(8'h43, 8'h08, "pin edge");
        // a write while the clock enable is low is lost
        @(posedge ref_clk);
        clk_en <= 1'b0;
        wr(`ICA_ADDR_MASK, 8'h07);
        clk_en <= 1'b1;
        rd(`ICA_ADDR_MASK, 8'h00, "mask frozen");
        finish_test();
    end
endmodule
